// File: verilog/fetx_encoder.sv
// 100 Mb/s transmit path: nibble capture, 4B/5B, scrambler, NRZI, MLT-3
`timescale 1ns/1ps
module fetx_encoder
    import fetx_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH, // Link-to-line buffer words
    parameter int BIT_CYCLES = BIT_CYC // Core cycles per line bit
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tx_clk_i,              // Transmit clock from pin
    input wire logic tx_en_i,               // MAC transmit enable
    input wire logic [NIB_W-1:0] txd_i,     // MAC transmit nibble
    input wire logic tx_er_i,               // MAC coding error request
    input wire logic [ADDR_W-1:0] phy_address_pins_i, // Seed source
    input wire logic scramble_bypass_i,     // High skips scrambler
    output logic line_pos_o,                // Positive drive stream
    output logic line_neg_o,                // Negative drive stream
    output logic line_bit_strobe_o,         // One cycle per line bit
    output logic tx_active_o,               // Frame in progress
    output logic overrun_o                  // Sticky: nibble lost
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [NIB_W+2:0] link_s;   // {clock, error, enable, nibble}
    logic [ADDR_W:0] static_s;  // {bypass, address}
    logic link_clk_d_r;         // Previous synced link clock

    fetx_sync #(.W(NIB_W + 3)) u_link_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({tx_clk_i, tx_er_i, tx_en_i, txd_i}),
        .q_o(link_s)
    );

    fetx_sync #(.W(ADDR_W + 1)) u_static_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({scramble_bypass_i, phy_address_pins_i}),
        .q_o(static_s)
    );

    wire link_clk_s = link_s[NIB_W+2];
    wire bypass_s = static_s[ADDR_W];
    wire [ADDR_W-1:0] addr_s = static_s[ADDR_W-1:0];
    // Capture at the falling edge: the MAC changes data after the
    // rising edge, so mid-period is the quiet point for the value
    // that the next rising edge would take
    wire link_fall = link_clk_d_r && !link_clk_s;

    // ****************************************************************
    // Nibble capture and hand-off to the buffer
    // ****************************************************************
    logic hold_r;                // Captured entry waiting
    logic [ENTRY_W-1:0] hold_d_r; // Captured entry
    logic overrun_r;             // Sticky loss flag
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [ENTRY_W-1:0] fifo_out_data;
    logic pop;                   // Code-group slot starts

    wire hold_taken = hold_r && fifo_in_ready;
    wire hold_blocked = hold_r && !fifo_in_ready;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_clk_d_r <= 1'b0;
            hold_r <= 1'b0;
            hold_d_r <= '0;
            overrun_r <= 1'b0;
        end else begin
            link_clk_d_r <= link_clk_s;
            // One entry per link period, in step with it   R17
            if (link_fall && !hold_blocked) begin
                hold_r <= 1'b1;
                hold_d_r <= link_s[ENTRY_W-1:0];
            end else if (hold_taken) begin
                hold_r <= 1'b0;
            end
            // Buffer stalled: the new nibble is dropped
            if (link_fall && hold_blocked) overrun_r <= 1'b1;
        end
    end

    fetx_fifo #(.W(ENTRY_W), .DEPTH(DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(hold_r),
        .in_ready_o(fifo_in_ready),
        .in_data_i(hold_d_r),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_out_data)
    );

    // ****************************************************************
    // Transmit control and code-group selection
    // ****************************************************************
    fetx_state_t state_r;        // Control state
    fetx_state_t state_nxt;
    logic [CG_W-1:0] cg_nxt;     // Code-group for this slot
    logic [CG_W-1:0] shift_r;    // Serialiser, MSB goes first
    logic [2:0] bit_cnt_r;       // Bits left in the slot
    wire ent_en = fifo_out_data[ENT_EN_POS];
    wire ent_er = fifo_out_data[ENT_ER_POS];
    wire [NIB_W-1:0] ent_nib = fifo_out_data[NIB_W-1:0];
    wire [CG_W-1:0] data_cg = fetx_enc(ent_nib); // R03

    // Every entry, framed or not, uses exactly one slot   R01
    assign pop = fifo_out_valid && (bit_cnt_r == 3'h0);

    // Next state and code-group of one slot   R02
    always_comb begin
        state_nxt = state_r;
        cg_nxt = CG_IDLE;
        case (state_r)
            ST_IDLE: begin
                if (ent_en) begin
                    cg_nxt = CG_J; // R04 R06
                    state_nxt = ST_SEND_K;
                end else begin
                    cg_nxt = CG_IDLE; // R04 R09
                end
            end
            ST_SEND_K: begin
                // Second preamble nibble gives way to K   R06
                cg_nxt = ent_en ? CG_K : CG_T;
                state_nxt = ent_en ? ST_DATA : ST_SEND_R;
            end
            ST_DATA: begin
                if (!ent_en) begin
                    cg_nxt = CG_T; // R08
                    state_nxt = ST_SEND_R;
                end else if (ent_er) begin
                    cg_nxt = CG_HALT; // R05
                end else begin
                    cg_nxt = data_cg; // R07
                end
            end
            ST_SEND_R: begin
                cg_nxt = CG_R; // R08
                state_nxt = ST_IDLE;
            end
            default: begin
                cg_nxt = CG_IDLE;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Bit timer and serialiser
    // ****************************************************************
    logic [15:0] tmr_r;          // Cycles into the current bit
    wire busy = bit_cnt_r != 3'h0;
    wire bit_tick = busy && (tmr_r == 16'(BIT_CYCLES - 1));
    wire nrz_bit = shift_r[CG_W-1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            shift_r <= CG_IDLE;
            bit_cnt_r <= 3'h0;
            tmr_r <= 16'h0000;
        end else begin
            if (pop) begin
                state_r <= state_nxt;
                shift_r <= cg_nxt;
                bit_cnt_r <= CG_BITS;
                tmr_r <= 16'h0000;
            end else if (bit_tick) begin
                shift_r <= {shift_r[CG_W-2:0], 1'b0};
                bit_cnt_r <= bit_cnt_r - 3'h1;
                tmr_r <= 16'h0000;
            end else if (busy) begin
                tmr_r <= tmr_r + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Scrambler
    // ****************************************************************
    logic [LFSR_W-1:0] lfsr_r;   // Scrambler state
    logic seeded_r;              // Seed taken after reset release
    logic [1:0] boot_r;          // Waits out the pin synchroniser refill
    wire key = lfsr_r[LFSR_TAP_HI] ^ lfsr_r[LFSR_TAP_LO]; // R10
    wire scr_bit = bypass_s ? nrz_bit : (nrz_bit ^ key);  // R11 R13
    // Address repeated around a one, so no address gives all zeros
    wire [LFSR_W-1:0] seed = {addr_s, SEED_FILL, addr_s};

    // The pins are caught a few cycles after reset, once synced
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_r <= '1;
            seeded_r <= 1'b0;
            boot_r <= 2'h0;
        end else if (!seeded_r) begin
            // Synced pins still read zero for two edges after release
            boot_r <= {boot_r[0], 1'b1};
            if (boot_r[1]) begin
                lfsr_r <= seed; // R12
                seeded_r <= 1'b1;
            end
        end else if (bit_tick) begin
            lfsr_r <= {lfsr_r[LFSR_W-2:0], key}; // R10
        end
    end

    // ****************************************************************
    // NRZI and MLT-3 line stage
    // ****************************************************************
    logic nrzi_r;                // NRZI level
    logic [1:0] mlt_r;           // MLT-3 phase
    logic [1:0] mlt_nxt;
    logic strobe_r;
    logic active_r;
    logic line_pos_r;            // Positive stream, straight from a flop
    logic line_neg_r;            // Negative stream, straight from a flop

    // A one toggles NRZI, and each NRZI transition steps MLT-3
    assign mlt_nxt = scr_bit ? mlt_r + 2'h1 : mlt_r; // R19

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nrzi_r <= 1'b0;
            mlt_r <= MLT_ZERO_A;
            strobe_r <= 1'b0;
            active_r <= 1'b0;
            line_pos_r <= 1'b0;
            line_neg_r <= 1'b0;
        end else begin
            strobe_r <= bit_tick;
            active_r <= (state_r != ST_IDLE);
            if (bit_tick) begin
                nrzi_r <= nrzi_r ^ scr_bit; // R14 R18
                mlt_r <= mlt_nxt;
                line_pos_r <= (mlt_nxt == MLT_PLUS); // R15
                line_neg_r <= (mlt_nxt == MLT_MINUS); // R15
            end
        end
    end

    // Only the split MLT-3 pair reaches the pins   R15 R16
    assign line_pos_o = line_pos_r;
    assign line_neg_o = line_neg_r;
    assign line_bit_strobe_o = strobe_r;
    assign tx_active_o = active_r;
    assign overrun_o = overrun_r;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    initial begin
        if (BIT_CYCLES < 1 || BIT_CYCLES > 65535)
            $error("fetx_encoder: bit cycles out of range");
        if (DEPTH < 2)
            $error("fetx_encoder: buffer depth below two");
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_capture;
        @(posedge clk_i) disable iff (rst_i)
        link_fall && !hold_blocked |=> hold_r;
    endproperty
    a_capture: assert property (p_capture) // R17
        else $error("link nibble not captured");

    property p_start_j;
        @(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_IDLE && ent_en
            |=> shift_r == CG_J && state_r == ST_SEND_K;
    endproperty
    a_start_j: assert property (p_start_j) // R06
        else $error("frame start did not send J");

    property p_k_follows;
        @(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_SEND_K && ent_en |=> shift_r == CG_K;
    endproperty
    a_k_follows: assert property (p_k_follows) // R06
        else $error("K did not follow J");

    property p_data_map;
        @(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_DATA && ent_en && !ent_er
            |=> shift_r == fetx_enc($past(ent_nib));
    endproperty
    a_data_map: assert property (p_data_map) // R07
        else $error("data nibble mis-encoded");

    property p_halt;
        @(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_DATA && ent_en && ent_er
            |=> shift_r == CG_HALT;
    endproperty
    a_halt: assert property (p_halt) // R05
        else $error("error nibble not sent as halt");

    property p_end_pair;
        @(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_DATA && !ent_en
            |=> shift_r == CG_T ##1 (!pop) [*4] ##1 (!pop || 1'b1);
    endproperty
    a_end_pair: assert property (p_end_pair) // R08
        else $error("end of frame did not send T");

    property p_r_then_idle;
        @(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_SEND_R
            |=> shift_r == CG_R && state_r == ST_IDLE;
    endproperty
    a_r_then_idle: assert property (p_r_then_idle) // R08
        else $error("R or return to idle missing");

    property p_idle_fill;
        @(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_IDLE && !ent_en |=> shift_r == CG_IDLE;
    endproperty
    a_idle_fill: assert property (p_idle_fill) // R09
        else $error("idle not sent between frames");

    property p_five_bits;
        @(posedge clk_i) disable iff (rst_i)
        pop |=> bit_cnt_r == CG_BITS;
    endproperty
    a_five_bits: assert property (p_five_bits) // R03
        else $error("slot is not five bits long");

    property p_nrzi;
        @(posedge clk_i) disable iff (rst_i)
        bit_tick |=> nrzi_r == ($past(nrzi_r) ^ $past(scr_bit));
    endproperty
    a_nrzi: assert property (p_nrzi) // R18
        else $error("NRZI level wrong");

    property p_bypass;
        @(posedge clk_i) disable iff (rst_i)
        bit_tick && bypass_s |=> nrzi_r == ($past(nrzi_r) ^ $past(nrz_bit));
    endproperty
    a_bypass: assert property (p_bypass) // R13
        else $error("bypass still scrambles");

    property p_pair_excl;
        @(posedge clk_i) disable iff (rst_i)
        !(line_pos_o && line_neg_o);
    endproperty
    a_pair_excl: assert property (p_pair_excl) // R15
        else $error("both drive streams active");

    property p_mlt_step;
        @(posedge clk_i) disable iff (rst_i)
        $changed(nrzi_r) |-> mlt_r == $past(mlt_r) + 2'h1;
    endproperty
    a_mlt_step: assert property (p_mlt_step) // R19
        else $error("MLT-3 did not step on transition");

    property p_seed;
        @(posedge clk_i) disable iff (rst_i)
        boot_r[1] && !seeded_r |=> lfsr_r == $past(seed);
    endproperty
    a_seed: assert property (p_seed) // R12
        else $error("scrambler seed not loaded");

    c_frame: cover property (@(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_SEND_R);
    c_halt: cover property (@(posedge clk_i) disable iff (rst_i)
        pop && state_r == ST_DATA && ent_en && ent_er);
    c_overrun: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(overrun_r));
    c_minus: cover property (@(posedge clk_i) disable iff (rst_i)
        line_neg_o);

endmodule

// File: verilog/fetx_pkg.sv
// Shared constants, code-groups and types of the 100 Mb/s transmit encoder
// ****************************************************************
// What this block does
// R01 - Nibbles become scrambled MLT-3 serial line stream
// R02 - Transmit control follows standard 100BASE-TX machine
// R03 - Each data nibble maps to fixed code-group
// R04 - Idle, start and end delimiters use fixed codes
// R05 - Code-group 00100 is the halt error code
// R06 - Start pair replaces first eight preamble bits
// R07 - Remaining preamble and data sent as code-groups
// R08 - Enable deasserted appends end delimiter pair
// R09 - Idles follow until enable asserts again
// R10 - Scrambler is closed-loop 11-bit LFSR
// R11 - Scrambler sequence XORed with serial NRZ stream
// R12 - Scrambler seed comes from PHY address pins
// R13 - Scrambler can be bypassed when not needed
// R14 - Scrambled stream is NRZI encoded before MLT-3
// R15 - MLT-3 splits into two alternating drive streams
// R16 - Only MLT-3 output, never plain binary
// R17 - Transmit clock 25 MHz, MAC data in step; code takes 60 ns per nibble slot, so a 25 MHz clock overruns the buffer
// R18 - NRZI toggles on one, holds on zero
// R19 - MLT-3 cycles zero, plus, zero, minus
// ****************************************************************
package fetx_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int NIB_W = 4;           // MII nibble width
    localparam int CG_W = 5;            // Code-group width
    localparam int ADDR_W = 5;          // PHY address pin width
    localparam int LFSR_W = 11;         // Scrambler length
    localparam int ENTRY_W = 6;         // Error, enable, nibble
    localparam int FIFO_DEPTH = 4;      // Words between link and line

    // ****************************************************************
    // Field positions of a FIFO entry
    // ****************************************************************
    localparam int ENT_ER_POS = 5;      // Coding error request
    localparam int ENT_EN_POS = 4;      // Transmit enable

    // ****************************************************************
    // Scrambler taps and seed layout
    // ****************************************************************
    localparam int LFSR_TAP_HI = 10;    // x^11 term
    localparam int LFSR_TAP_LO = 8;     // x^9 term
    localparam logic [0:0] SEED_FILL = 1'h1; // Keeps seed non-zero

    // ****************************************************************
    // Code-groups other than data
    // ****************************************************************
    localparam logic [4:0] CG_IDLE = 5'h1F;  // 11111
    localparam logic [4:0] CG_J = 5'h18;     // 11000
    localparam logic [4:0] CG_K = 5'h11;     // 10001
    localparam logic [4:0] CG_T = 5'h0D;     // 01101
    localparam logic [4:0] CG_R = 5'h07;     // 00111
    localparam logic [4:0] CG_HALT = 5'h04;  // 00100

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;  // Core clock 100 MHz
    localparam int BIT_TIME_NS = 8;     // One bit at 125 Mb/s
    localparam int LINK_PERIOD_NS = 40; // Transmit clock 25 MHz
    // Longest bit spacing, rounded down, never under one cycle
    localparam int BIT_CYC = (BIT_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                             (BIT_TIME_NS / CLK_PERIOD_NS);
    localparam logic [2:0] CG_BITS = 3'h5;   // Bits per code-group
    localparam logic [1:0] MLT_ZERO_A = 2'h0; // Level 0 before plus
    localparam logic [1:0] MLT_PLUS = 2'h1;   // Positive level
    localparam logic [1:0] MLT_ZERO_B = 2'h2; // Level 0 before minus
    localparam logic [1:0] MLT_MINUS = 2'h3;  // Negative level

    // ****************************************************************
    // Transmit control states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEND_K,
        ST_DATA,
        ST_SEND_R
    } fetx_state_t;

    // Data nibble to code-group
    function automatic logic [4:0] fetx_enc(input logic [3:0] nib);
        logic [4:0] cg;
        cg = 5'h1E;
        case (nib)
            4'h0: cg = 5'h1E;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0A;
            4'h5: cg = 5'h0B;
            4'h6: cg = 5'h0E;
            4'h7: cg = 5'h0F;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'hA: cg = 5'h16;
            4'hB: cg = 5'h17;
            4'hC: cg = 5'h1A;
            4'hD: cg = 5'h1B;
            4'hE: cg = 5'h1C;
            default: cg = 5'h1D;
        endcase
        return cg;
    endfunction

endpackage

// File: verilog/fetx_sync.sv
// Two-stage synchroniser for a group of slow external levels
`timescale 1ns/1ps
module fetx_sync #(
    parameter int W = 1 // Number of bits
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // ****************************************************************
    // Stages
    // ****************************************************************
    logic [W-1:0] meta_r; // First stage, read only by the second

    // Bits cross independently, so a word may show mixed old and new
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

    initial begin
        if (W < 1) $error("fetx_sync: width must be at least one");
    end
endmodule

// File: verilog/fetx_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module fetx_fifo #(
    parameter int W = 6,     // Word width
    parameter int DEPTH = 4  // Words, power of two
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    logic [W-1:0] mem_r [DEPTH]; // Word store
    logic [AW:0] wr_r;           // Write pointer with wrap bit
    logic [AW:0] rd_r;           // Read pointer with wrap bit
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // Full when pointers differ only in the wrap bit
    assign in_ready_o = (wr_r ^ rd_r) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_r != rd_r;
    assign out_data_o = mem_r[rd_r[AW-1:0]];

    // Pointers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) wr_r <= wr_r + 1'b1;
            if (pop) rd_r <= rd_r + 1'b1;
        end
    end

    // Data store needs no reset
    always_ff @(posedge clk_i) begin
        if (push) mem_r[wr_r[AW-1:0]] <= in_data_i;
    end

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("fetx_fifo: depth must be a power of two, at least 2");
    end
endmodule

// File: testbench/fetx_mac_model.sv
// MAC side model driving the transmit nibble bus
`timescale 1ns/1ps
module fetx_mac_model (
    output logic tx_clk_o,
    output logic tx_en_o,
    output logic [3:0] txd_o,
    output logic tx_er_o
);
    int hp = 80; // Half period in ns; t_overrun shortens it to 20 to force a buffer overrun
    // ****************
    // Transmit clock runs free, as it does between frames too
    // ****************
    initial begin
        tx_clk_o = 1'b0;
        tx_en_o = 1'b0;
        txd_o = 4'h0;
        tx_er_o = 1'b0;
        forever #(hp) tx_clk_o = ~tx_clk_o;
    end
    // One nibble per period, changed just after the rising edge
    task automatic put(input logic en, input logic [3:0] d, input logic er);
        @(posedge tx_clk_o);
        #2;
        tx_en_o = en;
        // Outside a frame the nibble is junk, so it keeps changing
        txd_o = en ? d : ~txd_o;
        tx_er_o = er;
    endtask
endmodule

// File: testbench/fetx_encoder_tb.sv
// Self-checking bench for the transmit encoder
`timescale 1ns/1ps
module fetx_encoder_tb;
    import fetx_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, byp = 1'b0, tx_clk, tx_en, tx_er;
    logic pos, neg, stb, act, ovr;
    logic [3:0] txd;
    logic [4:0] addr = 5'h13, sh = 5'h00;
    logic [10:0] lf = 11'h000; // Own descrambler state
    logic [1:0] ph = 2'h0, prv = 2'h0; // Expected line phase, last level
    logic [4:0] gq[$]; // Recovered code-groups
    logic [4:0] tbl[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
        5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    int n_fail = 0, checked = 0, cyc = 0, nb = 0;
    logic b, k;
    fetx_mac_model mac (.tx_clk_o(tx_clk), .tx_en_o(tx_en), .txd_o(txd),
        .tx_er_o(tx_er));
    fetx_encoder dut (.clk_i(clk_i), .rst_i(rst_i), .tx_clk_i(tx_clk),
        .tx_en_i(tx_en), .txd_i(txd), .tx_er_i(tx_er),
        .phy_address_pins_i(addr), .scramble_bypass_i(byp),
        .line_pos_o(pos), .line_neg_o(neg), .line_bit_strobe_o(stb),
        .tx_active_o(act), .overrun_o(ovr));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk_cg(input logic [4:0] g, input logic [4:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t group %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_lv(input logic [1:0] g, input logic [1:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t line level %b expected %b", $time, g, e);
        end
    endtask
    // ****************
    // Line monitor: MLT-3 back to NRZI bits, then descramble and frame
    // ****************
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++; // Hung run counts as a mismatch
            wrap_up();
        end
        if (rst_i) begin
            lf = {addr, 1'b1, addr};
            ph = 2'h0;
            prv = 2'h0;
            nb = 0;
        end else if (stb) begin
            b = ({pos, neg} != prv);
            prv = {pos, neg};
            ph = ph + {1'b0, b};
            chk_lv({pos, neg}, {ph == 2'h1, ph == 2'h3});
            k = lf[10] ^ lf[8];
            lf = {lf[9:0], k};
            sh = {sh[3:0], byp ? b : b ^ k};
            nb++;
            if (nb == 5) begin
                gq.push_back(sh);
                nb = 0;
            end
        end
    end
    task automatic do_reset(input logic [4:0] a, input logic bp);
        @(posedge clk_i);
        #1;
        rst_i = 1'b1;
        addr = a;
        byp = bp;
        repeat (16) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        gq.delete();
    endtask
    // Find the first J and compare what follows, idle just before it
    task automatic chk_frame(input logic [4:0] e[$]);
        int j;
        j = -1;
        repeat (600) @(posedge clk_i);
        foreach (gq[i]) if (j < 0 && gq[i] === CG_J) j = i;
        if (j < 1 || j + e.size() > gq.size()) chk_cg(5'h00, CG_J);
        else begin
            chk_cg(gq[j - 1], CG_IDLE);
            foreach (e[i]) chk_cg(gq[j + i], e[i]);
        end
    endtask
    task automatic t_full;
        logic [4:0] e[$];
        do_reset(5'h13, 1'b0);
        e = {CG_J, CG_K};
        repeat (3) mac.put(1'b0, 4'h0, 1'b0);
        mac.put(1'b1, 4'h5, 1'b0);
        mac.put(1'b1, 4'h5, 1'b0);
        for (int i = 0; i < 16; i++) begin
            mac.put(1'b1, i[3:0], 1'b0);
            e.push_back(tbl[i]);
        end
        mac.put(1'b1, 4'h3, 1'b1);
        chk_lv({act, 1'b0}, 2'h2);
        e = {e, CG_HALT, CG_T, CG_R, CG_IDLE, CG_IDLE};
        repeat (4) mac.put(1'b0, 4'h0, 1'b0);
        chk_frame(e);
        chk_lv({act, ovr}, 2'h0);
        $display("test full frame done");
    endtask
    task automatic t_bypass;
        do_reset(5'h0A, 1'b1);
        repeat (3) mac.put(1'b0, 4'h0, 1'b0);
        mac.put(1'b1, 4'h5, 1'b0);
        repeat (4) mac.put(1'b0, 4'h0, 1'b0);
        chk_frame('{CG_J, CG_T, CG_R, CG_IDLE});
        $display("test bypass done");
    endtask
    task automatic t_overrun;
        do_reset(5'h01, 1'b0);
        mac.hp = 20;
        repeat (24) mac.put(1'b1, 4'hA, 1'b0);
        mac.hp = 80;
        repeat (4) mac.put(1'b0, 4'h0, 1'b0);
        chk_lv({ovr, 1'b0}, 2'h2);
        $display("test overrun done");
    endtask
    task automatic wrap_up;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        t_full();
        t_bypass();
        t_overrun();
        wrap_up();
    end
endmodule
